// ===== src/csw_top.sv
`default_nettype none
`include "csw_defines.svh"

module csw_top
    import csw_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           sys_rst,
    input  wire logic           switch_enable_cfg,
    input  wire logic [2:0]     initial_source_cfg,
    input  wire logic [1:0]     primary_submode_cfg,
    input  wire logic           wdt_lowpower_rc_osc_request,
    input  wire logic           sleep_mode,
    input  wire logic           key_wr,
    input  wire logic [7:0]     key_data,
    input  wire logic           wr_en,
    input  wire logic           wr_high,
    input  wire logic [7:0]     wr_data,
    input  wire logic           startup_timer_done,
    input  wire logic           pll_lock_in,
    input  wire csw_osc_s       src_tick,
    output logic [15:0]         osc_control_reg,
    output csw_osc_s            osc_on,
    output logic                pll_on,
    output logic [2:0]          sys_clk_sel,
    output logic [1:0]          primary_submode,
    output logic                clock_fail_trap,
    output logic                switch_busy
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Oscillator that a source code needs
    function automatic csw_osc_s osc_of(input logic [2:0] src);
        csw_osc_s o;
        o = '0;
        unique case (src)
            `CSW_SRC_FRC, `CSW_SRC_FRC_PLL: o.fast_rc_osc  = 1'b1;
            `CSW_SRC_PRI, `CSW_SRC_PRI_PLL: o.pri  = 1'b1;
            `CSW_SRC_LP:                    o.lp   = 1'b1;
            default:                        o.lowpower_rc_osc = 1'b1;
        endcase
        return o;
    endfunction
    // Source runs through the PLL
    function automatic logic uses_pll(input logic [2:0] src);
        return (src == `CSW_SRC_FRC_PLL) || (src == `CSW_SRC_PRI_PLL);
    endfunction
    // Source is a crystal needing the start-up timer
    function automatic logic is_crystal(input logic [2:0] src, input logic [1:0] sub);
        return (src == `CSW_SRC_LP) ||
               (((src == `CSW_SRC_PRI) || (src == `CSW_SRC_PRI_PLL)) && (sub != `CSW_SUB_EC));
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    csw_state_e  state,     next_state;
    logic [2:0]  cur_src,   next_cur_src;
    logic [2:0]  new_src,   next_new_src;
    logic        req,       next_req;
    logic        lock_stat, next_lock_stat;
    logic        fail_flag, next_fail_flag;
    logic        keep_lp,   next_keep_lp;
    logic [1:0]  key_stage, next_key_stage;
    logic [3:0]  settle,    next_settle;
    logic [3:0]  win,       next_win;
    logic        was_on,    next_was_on;
    logic        trap,      next_trap;
    csw_osc_s    osc_en,    next_osc_en;
    logic        pll_en,    next_pll_en;
    logic [1:0]  submode,   next_submode;
    logic        sw_on;
    logic        failsafe_monitor_on;
    logic        unlocked;
    csw_osc_s    tgt_osc;
    csw_osc_s    cur_osc;
    logic        tgt_tick;
    logic        cur_tick;
    logic        fail_now;
    // Enables, unlock state and oscillator views
    assign sw_on    = ~switch_enable_cfg;
    assign failsafe_monitor_on  = sw_on;
    assign unlocked = (key_stage == 2'h2);
    assign tgt_osc  = osc_of(new_src);
    assign cur_osc  = osc_of(cur_src);
    assign tgt_tick = |(src_tick & tgt_osc);
    assign cur_tick = |(src_tick & cur_osc);
    assign fail_now = failsafe_monitor_on && !sleep_mode && src_tick.lowpower_rc_osc && !cur_tick
                      && (win == `CSW_FAIL_WINDOW - 4'h1);

    // ----------------------------------------------------------------
    // Next-value logic
    // ----------------------------------------------------------------
    // Unlock keys, register writes, switch sequencer and fail monitor
    always_comb begin
        next_state     = state;
        next_cur_src   = cur_src;
        next_new_src   = new_src;
        next_req       = req;
        next_lock_stat = lock_stat && pll_lock_in && pll_en;
        next_fail_flag = fail_flag;
        next_keep_lp   = keep_lp;
        next_key_stage = 2'h0;
        next_settle    = settle;
        next_win       = win;
        next_was_on    = was_on;
        next_trap      = 1'b0;
        next_submode   = primary_submode_cfg;
        // Two keys back to back arm one following write
        if (key_wr && key_data == `CSW_KEY_FIRST) begin
            next_key_stage = 2'h1;
        end else if (key_wr && key_data == `CSW_KEY_SECOND && key_stage == 2'h1) begin
            next_key_stage = 2'h2;
        end
        // Byte writes only while unlocked
        if (wr_en && unlocked) begin
            if (wr_high) begin
                next_new_src = wr_data[`CSW_NEW_LSB-8 +: 3];
            end else begin
                next_keep_lp = wr_data[`CSW_KEEP_BIT];
                if (!wr_data[`CSW_FAIL_BIT]) begin
                    next_fail_flag = 1'b0;
                end
                if (wr_data[`CSW_REQ_BIT] && sw_on && state == ST_IDLE) begin
                    next_req   = 1'b1;
                    next_state = ST_CHECK;
                end
            end
        end

        // Switch sequence; processor is never stalled
        unique case (state)
            ST_IDLE: ;
            ST_CHECK: begin
                if (new_src == cur_src) begin
                    next_req   = 1'b0;
                    next_state = ST_IDLE;
                end else begin
                    next_lock_stat = 1'b0;
                    next_fail_flag = 1'b0;
                    next_was_on    = |(osc_en & tgt_osc);
                    next_state     = ST_START;
                end
            end
            ST_START: begin
                if ((!is_crystal(new_src, submode) || was_on || startup_timer_done) &&
                    (!uses_pll(new_src) || pll_lock_in)) begin
                    next_settle = 4'h0;
                    next_state  = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (tgt_tick) begin
                    next_settle = settle + 4'h1;
                    if (settle == `CSW_SETTLE_CYCLES - 4'h1) begin
                        next_state = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                next_cur_src = new_src;
                next_req     = 1'b0;
                next_state   = ST_IDLE;
            end
        endcase
        // Lock status follows the PLL while idle on a PLL source
        if (uses_pll(cur_src) && pll_lock_in && pll_en && state == ST_IDLE) begin
            next_lock_stat = 1'b1;
        end

        // Missing-edge window counted in low-power RC ticks
        if (!failsafe_monitor_on || cur_tick) begin
            next_win = 4'h0;
        end else if (src_tick.lowpower_rc_osc) begin
            next_win = win + 4'h1;
        end

        // Failure: trap and fall back to fast RC, keeping the PLL only if the failed source used it
        if (fail_now) begin
            next_fail_flag = 1'b1;
            next_trap      = 1'b1;
            next_cur_src   = uses_pll(cur_src) ? `CSW_SRC_FRC_PLL : `CSW_SRC_FRC;
            next_req       = 1'b0;
            next_win       = 4'h0;
            next_state     = ST_IDLE;
        end

        // Disabled switching pins status to config and kills request
        if (!sw_on) begin
            next_cur_src = initial_source_cfg;
            next_req     = 1'b0;
            next_state   = ST_IDLE;
        end
    end

    // Oscillator enables: current, target while switching, kept ones
    always_comb begin
        next_osc_en = osc_of(next_cur_src);
        next_pll_en = uses_pll(next_cur_src);
        if (next_state != ST_IDLE && next_state != ST_CHECK) begin
            next_osc_en = next_osc_en | tgt_osc;
            next_pll_en = next_pll_en | uses_pll(new_src);
        end
        if (next_keep_lp) begin
            next_osc_en.lp = 1'b1;
        end
        if (failsafe_monitor_on) begin
            next_osc_en.lowpower_rc_osc = !sleep_mode;
        end else if (wdt_lowpower_rc_osc_request) begin
            next_osc_en.lowpower_rc_osc = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Register all state; reset catches the initial source
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= ST_IDLE;
            cur_src   <= initial_source_cfg;
            new_src   <= initial_source_cfg;
            req       <= 1'b0;
            lock_stat <= 1'b0;
            fail_flag <= 1'b0;
            keep_lp   <= 1'b0;
            key_stage <= 2'h0;
            settle    <= 4'h0;
            win       <= 4'h0;
            was_on    <= 1'b0;
            trap      <= 1'b0;
            osc_en    <= osc_of(initial_source_cfg);
            pll_en    <= uses_pll(initial_source_cfg);
            submode   <= primary_submode_cfg;
        end else begin
            state     <= next_state;
            cur_src   <= next_cur_src;
            new_src   <= next_new_src;
            req       <= next_req;
            lock_stat <= next_lock_stat;
            fail_flag <= next_fail_flag;
            keep_lp   <= next_keep_lp;
            key_stage <= next_key_stage;
            settle    <= next_settle;
            win       <= next_win;
            was_on    <= next_was_on;
            trap      <= next_trap;
            osc_en    <= next_osc_en;
            pll_en    <= next_pll_en;
            submode   <= next_submode;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Control/status word from the source, status and request registers
    always_comb begin
        osc_control_reg                      = 16'h0000;
        osc_control_reg[`CSW_CUR_LSB +: 3]   = cur_src;
        osc_control_reg[`CSW_NEW_LSB +: 3]   = new_src;
        osc_control_reg[`CSW_LOCK_BIT]       = lock_stat;
        osc_control_reg[`CSW_FAIL_BIT]       = fail_flag;
        osc_control_reg[`CSW_KEEP_BIT]       = keep_lp;
        osc_control_reg[`CSW_REQ_BIT]        = req;
    end
    // Oscillator controls and status pins
    assign osc_on          = osc_en;
    assign pll_on          = pll_en;
    assign sys_clk_sel     = cur_src;
    assign primary_submode = submode;
    assign clock_fail_trap = trap;
    assign switch_busy     = (state != ST_IDLE);

endmodule // csw_top
`default_nettype wire

// ===== src/csw_defines.svh
`ifndef CSW_DEFINES_SVH
`define CSW_DEFINES_SVH

// Source codes for the new/current source fields
`define CSW_SRC_FRC        3'h0
`define CSW_SRC_FRC_PLL    3'h1
`define CSW_SRC_PRI        3'h2
`define CSW_SRC_PRI_PLL    3'h3
`define CSW_SRC_LP         3'h4
`define CSW_SRC_LOWPOWER_RC_OSC       3'h5

// Primary submode codes
`define CSW_SUB_EC         2'h0
`define CSW_SUB_MS         2'h1
`define CSW_SUB_HS         2'h2

// Control register field positions
`define CSW_CUR_LSB        12
`define CSW_NEW_LSB        8
`define CSW_LOCK_BIT       5
`define CSW_FAIL_BIT       3
`define CSW_KEEP_BIT       1
`define CSW_REQ_BIT        0

// Unlock keys, written back to back
`define CSW_KEY_FIRST      8'h5a
`define CSW_KEY_SECOND     8'ha5

// Timing counts
`define CSW_SETTLE_CYCLES  4'ha
`define CSW_FAIL_WINDOW    4'h3

`endif

// ===== src/csw_pkg.sv
`default_nettype none
package csw_pkg;

    // Per-oscillator bundle: enables and clock ticks
    typedef struct packed {
        logic fast_rc_osc;
        logic pri;
        logic lp;
        logic lowpower_rc_osc;
    } csw_osc_s;

    // Switch sequencer states
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_CHECK  = 5'h02,
        ST_START  = 5'h04,
        ST_SETTLE = 5'h08,
        ST_DONE   = 5'h10
    } csw_state_e;

endpackage
`default_nettype wire

// ===== sim/csw_top_asserts.sv
`default_nettype none
module csw_top_asserts
    import csw_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        switch_enable_cfg,
    input wire logic [2:0]  initial_source_cfg,
    input wire logic [1:0]  primary_submode_cfg,
    input wire logic        sleep_mode,
    input wire logic [15:0] osc_control_reg,
    input wire csw_osc_s    osc_on,
    input wire logic [1:0]  primary_submode,
    input wire logic        clock_fail_trap,
    input wire logic        switch_busy
);
    // --------------------------------
    // Register field views
    // --------------------------------
    logic [2:0] cur_src;
    logic [2:0] new_src;
    logic       req;
    logic       fail;
    logic       lock;

    // Slices of the control register
    assign cur_src = osc_control_reg[14:12];
    assign new_src = osc_control_reg[10:8];
    assign req     = osc_control_reg[0];
    assign fail    = osc_control_reg[3];
    assign lock    = osc_control_reg[5];

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    // --------------------------------
    // Properties
    // --------------------------------
    chk_off_req_low: assert property (switch_enable_cfg && $past(switch_enable_cfg) |-> !req)
        else $error("request bit set while switching is off");
    chk_off_cur_cfg: assert property (
        switch_enable_cfg && $stable(initial_source_cfg) |-> cur_src == initial_source_cfg)
        else $error("current source differs from configured source");
    chk_submode_cfg: assert property (
        !$past(sys_rst) |-> primary_submode == $past(primary_submode_cfg))
        else $error("primary submode not taken from configuration");
    chk_redundant_abort: assert property ($rose(req) && cur_src == new_src |-> ##[1:2] !req)
        else $error("redundant request not aborted");
    chk_start_clear: assert property (
        $rose(req) && cur_src != new_src |-> ##[1:2] (!lock && !fail))
        else $error("lock or fail status not cleared at switch start");
    chk_done_copy: assert property (
        $fell(switch_busy) && !clock_fail_trap |-> cur_src == new_src && !req)
        else $error("switch end without copy or request clear");
    chk_cur_moves: assert property (
        !$past(sys_rst) && !switch_enable_cfg && $changed(cur_src)
        |-> clock_fail_trap || $past(switch_busy))
        else $error("current source moved outside a switch");
    chk_lowpower_rc_osc_runs: assert property (
        !$past(sys_rst) && !switch_enable_cfg && !sleep_mode
        && $past(!switch_enable_cfg && !sleep_mode) |-> osc_on.lowpower_rc_osc)
        else $error("low-power RC stopped while monitor on");
    chk_trap_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
        else $error("trap longer than one cycle");
    chk_fail_to_frc: assert property (clock_fail_trap |-> fail
        && cur_src == (($past(cur_src) inside {3'h1, 3'h3}) ? 3'h1 : 3'h0))
        else $error("failure did not fall back to fast RC");

    // Main scenarios reached
    cov_switch_done: cover property ($fell(switch_busy));
    cov_trap: cover property (clock_fail_trap);
    cov_redundant: cover property ($rose(req) && cur_src == new_src);
endmodule // csw_top_asserts

bind csw_top csw_top_asserts i_chk (
    .clk(clk), .sys_rst(sys_rst), .switch_enable_cfg(switch_enable_cfg),
    .initial_source_cfg(initial_source_cfg), .primary_submode_cfg(primary_submode_cfg),
    .sleep_mode(sleep_mode), .osc_control_reg(osc_control_reg), .osc_on(osc_on),
    .primary_submode(primary_submode), .clock_fail_trap(clock_fail_trap),
    .switch_busy(switch_busy)
);
`default_nettype wire

// ===== sim/csw_top_tb_top.sv
`default_nettype none
`include "csw_defines.svh"
module csw_top_tb_top
    import csw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------
    // Signals
    // --------------------------------
    logic        clk, sys_rst, switch_enable_cfg, key_wr, wr_en, wr_high, sleep_mode;
    logic        startup_timer_done, pll_lock_in, wdt_lowpower_rc_osc_request;
    logic        pll_on, clock_fail_trap, switch_busy;
    logic [2:0]  initial_source_cfg, sys_clk_sel, cur_src;
    logic [1:0]  primary_submode_cfg, primary_submode;
    logic [7:0]  key_data, wr_data;
    logic [15:0] osc_control_reg;
    logic [3:0]  tick_en;
    csw_osc_s    src_tick, osc_on;
    int          fails, checked, cyc;

    assign cur_src = osc_control_reg[14:12];

    csw_top i_dut (
        .clk(clk), .sys_rst(sys_rst), .switch_enable_cfg(switch_enable_cfg),
        .initial_source_cfg(initial_source_cfg), .primary_submode_cfg(primary_submode_cfg),
        .wdt_lowpower_rc_osc_request(wdt_lowpower_rc_osc_request), .sleep_mode(sleep_mode), .key_wr(key_wr),
        .key_data(key_data), .wr_en(wr_en), .wr_high(wr_high), .wr_data(wr_data),
        .startup_timer_done(startup_timer_done), .pll_lock_in(pll_lock_in),
        .src_tick(src_tick), .osc_control_reg(osc_control_reg), .osc_on(osc_on),
        .pll_on(pll_on), .sys_clk_sel(sys_clk_sel), .primary_submode(primary_submode),
        .clock_fail_trap(clock_fail_trap), .switch_busy(switch_busy)
    );

    // Clock generation
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Oscillator ticks at fixed ratios while enabled, and the run limit
    always @(posedge clk) begin
        #1;
        cyc = cyc + 1;
        src_tick.fast_rc_osc  = osc_on.fast_rc_osc && tick_en[3] && (cyc % 2 == 0);
        src_tick.pri  = osc_on.pri && tick_en[2] && (cyc % 3 == 0);
        src_tick.lp   = osc_on.lp && tick_en[1] && (cyc % 4 == 0);
        src_tick.lowpower_rc_osc = osc_on.lowpower_rc_osc && tick_en[0] && (cyc % 8 == 0);
        if (cyc > 20000) begin
            fails++;
            finish_test();
        end
    end

    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Keys back to back, then the byte write
    task automatic wr_byte(input logic hi, input logic [7:0] d);
        @(posedge clk);
        #1 key_wr = 1'h1;
        key_data = `CSW_KEY_FIRST;
        @(posedge clk);
        #1 key_data = `CSW_KEY_SECOND;
        @(posedge clk);
        #1 key_wr = 1'h0;
        wr_en = 1'h1;
        wr_high = hi;
        wr_data = d;
        @(posedge clk);
        #1 wr_en = 1'h0;
    endtask

    task automatic switch_to(input logic [2:0] tgt, input logic [7:0] lo);
        wr_byte(1'h1, {5'h00, tgt});
        check("new source", 16'(tgt), 16'(osc_control_reg[10:8]));
        wr_byte(1'h0, lo);
    endtask

    task automatic wait_idle(output int n);
        n = 0;
        while (switch_busy !== 1'h0 && n < 500) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 500) begin
            fails++;
            $display("unexpected busy: expected 0, seen 1");
        end
    endtask

    task automatic wait_cycles(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic finish_test();
        $display("checked %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // --------------------------------
    // Test sequence
    // --------------------------------
    initial begin
        int n;
        logic [2:0] tgts [5];
        tgts = '{3'h0, 3'h1, 3'h0, 3'h4, 3'h5};
        {sys_rst, switch_enable_cfg, initial_source_cfg} = {1'h1, 1'h0, `CSW_SRC_FRC};
        {primary_submode_cfg, wdt_lowpower_rc_osc_request, sleep_mode} = {`CSW_SUB_HS, 2'h0};
        {key_wr, key_data, wr_en, wr_high, wr_data} = 19'h00000;
        {startup_timer_done, pll_lock_in, tick_en} = 6'h0f;
        {fails, checked, cyc} = {32'h0, 32'h0, 32'h0};
        wait_cycles(12);
        sys_rst = 1'h0;
        wait_cycles(2);
        check("control", 16'h0000, osc_control_reg);
        check("oscillators", 16'h0009, 16'(osc_on));
        check("submode", 16'h0002, 16'(primary_submode));
        @(posedge clk);
        #1 wr_en = 1'h1;
        wr_high = 1'h1;
        wr_data = 8'h04;
        wait_cycles(2);
        wr_en = 1'h0;
        check("new source", 16'h0000, 16'(osc_control_reg[10:8]));
        $display("test reset_and_lock done");
        switch_to(`CSW_SRC_FRC, 8'h01);
        check("request", 16'h0001, 16'(osc_control_reg[0]));
        wait_cycles(3);
        check("request", 16'h0000, 16'(osc_control_reg[0]));
        check("current", 16'h0000, 16'(cur_src));
        $display("test redundant done");
        switch_to(`CSW_SRC_PRI, 8'h01);
        wait_cycles(20);
        check("busy", 16'h0001, 16'(switch_busy));
        check("current", 16'h0000, 16'(cur_src));
        startup_timer_done = 1'h1;
        wait_idle(n);
        check("settle count", 16'h0001, 16'(n >= 30 && n <= 32));
        check("current", 16'(`CSW_SRC_PRI), 16'(cur_src));
        check("clock select", 16'(`CSW_SRC_PRI), 16'(sys_clk_sel));
        check("oscillators", 16'h0005, 16'(osc_on));
        switch_to(`CSW_SRC_PRI_PLL, 8'h01);
        wait_cycles(20);
        check("busy", 16'h0001, 16'(switch_busy));
        pll_lock_in = 1'h1;
        wait_idle(n);
        wait_cycles(2);
        check("lock", 16'h0001, 16'(osc_control_reg[5]));
        check("current", 16'(`CSW_SRC_PRI_PLL), 16'(cur_src));
        $display("test switch_waits done");
        tick_en[2] = 1'h0;
        n = 0;
        while (clock_fail_trap !== 1'h1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        check("trap", 16'h0001, 16'(clock_fail_trap));
        check("current", 16'(`CSW_SRC_FRC_PLL), 16'(cur_src));
        check("fail flag", 16'h0001, 16'(osc_control_reg[3]));
        check("pll", 16'h0001, 16'(pll_on));
        tick_en[2] = 1'h1;
        {sleep_mode, wdt_lowpower_rc_osc_request} = 2'h3;
        wait_cycles(2);
        check("oscillators", 16'h0008, 16'(osc_on));
        {sleep_mode, wdt_lowpower_rc_osc_request} = 2'h0;
        wait_cycles(2);
        check("oscillators", 16'h0009, 16'(osc_on));
        $display("test failure done");
        foreach (tgts[i]) begin
            switch_to(tgts[i], (i == 4) ? 8'h03 : 8'h01);
            wait_idle(n);
            check("current", 16'(tgts[i]), 16'(cur_src));
        end
        check("oscillators", 16'h0003, 16'(osc_on) & 16'h000b);
        check("keep", 16'h0001, 16'(osc_control_reg[1]));
        $display("test all_sources done");
        {sys_rst, switch_enable_cfg, initial_source_cfg} = {1'h1, 1'h1, `CSW_SRC_LP};
        primary_submode_cfg = `CSW_SUB_MS;
        wait_cycles(12);
        sys_rst = 1'h0;
        switch_to(`CSW_SRC_FRC, 8'h01);
        check("request", 16'h0000, 16'(osc_control_reg[0]));
        wait_cycles(3);
        check("current", 16'(`CSW_SRC_LP), 16'(cur_src));
        check("oscillators", 16'h0002, 16'(osc_on));
        wdt_lowpower_rc_osc_request = 1'h1;
        wait_cycles(2);
        check("oscillators", 16'h0003, 16'(osc_on));
        initial_source_cfg = `CSW_SRC_LOWPOWER_RC_OSC;
        wait_cycles(2);
        check("current", 16'(`CSW_SRC_LOWPOWER_RC_OSC), 16'(cur_src));
        check("submode", 16'(`CSW_SUB_MS), 16'(primary_submode));
        $display("test disabled done");
        finish_test();
    end
endmodule // csw_top_tb_top
`default_nettype wire
